/* inc/rsp_cfg.svh */
// Behaviour
// R1: a reply always starts with its descriptor, then the data packets follow.
// R2: one descriptor per session, however many data packets follow it.
// R3: each descriptor opens with sync bytes A5 then 5A.
// R4: descriptor then carries 30-bit packet length, 2-bit send mode, one type byte.
// R5: all data packets of a session share the announced length.
// R6: send mode 0 means one packet, 1 means a stream; 2 and 3 never sent.
// R7: the type byte names the kind of data, taken from the request.
// R8: four main states: idle, scanning, request processing, fault halt.
// R9: idle after reset; laser and measurement off, low power.
// R10: scanning turns laser and measurement on and streams results.
// R11: a request enters processing; nothing is sent until the operation ends.
// R12: after processing, go to the state the request names.
// R13: a hardware fault abandons the current work and enters fault halt.
// R14: fault halt still answers queries but refuses scans until a core reset.
// R15: scanning sends results only once motor rotation is stable.
// R16: code 25 goes idle, code 40 reboots the core; neither replies.
// R17: code 20 starts scanning with a continuous stream.
// R18: code 82 with payload scans at top speed with a continuous stream.
// R19: code 21 scans and streams without waiting for motor stability.
// R20: codes 50, 52, 59 answer with one descriptor and one packet.
// R21: code 84 with payload answers one packet of scan mode configuration.
// R22: multi-byte fields go out least significant byte first.
// R23: requests arriving while one is still pending are dropped.
// R24: a request during a stream ends it, then is processed.
// R25: length and mode form one little-endian word, mode in the top bits.
`ifndef RSP_CFG_SVH
`define RSP_CFG_SVH

// ****************************************************************
// protocol constants
// ****************************************************************
`define RSP_SYNC1        8'hA5
`define RSP_SYNC2        8'h5A
`define RSP_MODE_SINGLE  2'h0
`define RSP_MODE_STREAM  2'h1
`define RSP_DESC_LAST    30'h00000006
`define RSP_CMD_STOP     8'h25
`define RSP_CMD_REBOOT   8'h40
`define RSP_CMD_SCAN     8'h20
`define RSP_CMD_FAST     8'h82
`define RSP_CMD_FORCE    8'h21
`define RSP_CMD_IDENT    8'h50
`define RSP_CMD_COND     8'h52
`define RSP_CMD_PERIOD   8'h59
`define RSP_CMD_CONF     8'h84

// ****************************************************************
// register map
// ****************************************************************
`define RSP_OFF_STATUS   8'h00
`define RSP_OFF_DROPS    8'h04
`define RSP_OFF_LEN0     8'h10
`define RSP_NUM_LEN      7
`define RSP_LEN_RST      30'h00000005
`define RSP_STS_STATE    0
`define RSP_STS_PH       2
`define RSP_STS_FAULT    4
`define RSP_STS_PEND     5

// ****************************************************************
// timing
// ****************************************************************
`define RSP_CLK_NS       40
`define RSP_PROC_NS      1000
`define RSP_PROC_CYC     ((`RSP_PROC_NS + `RSP_CLK_NS - 1) / `RSP_CLK_NS)

`endif

/* inc/rsp_pkg.sv */
`include "rsp_cfg.svh"
package rsp_pkg;

    typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_PROC, ST_FAULT} rsp_state_e;
    typedef enum logic [1:0] {PH_OFF, PH_DESC, PH_DATA} rsp_txph_e;
    typedef logic [29:0] rsp_len_t;

    // length register that serves each reply kind
    function automatic logic [2:0] rsp_len_idx(input logic [7:0] c);
        case (c)
            `RSP_CMD_SCAN:   rsp_len_idx = 3'h0;
            `RSP_CMD_FAST:   rsp_len_idx = 3'h1;
            `RSP_CMD_FORCE:  rsp_len_idx = 3'h2;
            `RSP_CMD_IDENT:  rsp_len_idx = 3'h3;
            `RSP_CMD_COND:   rsp_len_idx = 3'h4;
            `RSP_CMD_PERIOD: rsp_len_idx = 3'h5;
            default:         rsp_len_idx = 3'h6;
        endcase
    endfunction

endpackage

/* logic/rsp_sync2.sv */
`timescale 1ns/1ps
module rsp_sync2 #(
    parameter int W = 2
) (
    input  logic         clk,
    input  logic         rst,
    input  logic         ce,
    input  logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r;

    // ****************************************************************
    // two flops per bit
    // ****************************************************************
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk) begin
            if (rst) begin
                s1_r[i] <= 1'h0;
                q[i]    <= 1'h0;
            end else if (ce) begin
                s1_r[i] <= d[i];
                q[i]    <= s1_r[i];
            end
        end
    end
endmodule

/* logic/rsp_desc_byte.sv */
`timescale 1ns/1ps
`include "rsp_cfg.svh"
module rsp_desc_byte
    import rsp_pkg::*;
(
    input  logic [2:0] idx,
    input  rsp_len_t   len,
    input  logic [1:0] mode,
    input  logic [7:0] dtype,
    output logic [7:0] byte_o
);
    // ****************************************************************
    // descriptor image, byte 0 first
    // ****************************************************************
    wire logic [31:0] len_word = {mode, len};              // [R25]
    wire logic [55:0] image    = {dtype, len_word, `RSP_SYNC2, `RSP_SYNC1}; // [R3] [R4] [R7]
    wire logic [5:0]  bit_ofs  = {idx, 3'h0};

    assign byte_o = (idx < 3'h7) ? image[bit_ofs +: 8] : 8'h00; // [R22]
endmodule

/* logic/rsp_top.sv */
`timescale 1ns/1ps
`include "rsp_cfg.svh"
module rsp_top
    import rsp_pkg::*;
#(
    parameter int PROC_CYC = `RSP_PROC_CYC,
    parameter int DROP_W   = 16
) (
    input  logic        REF_CLK,
    input  logic        RST,
    input  logic        CE,
    input  logic        PSEL,
    input  logic        PENABLE,
    input  logic        PWRITE,
    input  logic [7:0]  PADDR,
    input  logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic        PREADY,
    output logic        PSLVERR,
    input  logic        REQ_VALID,
    input  logic [7:0]  REQ_CMD,
    input  logic        MOTOR_STABLE,
    input  logic        HW_FAULT,
    input  logic        DATA_VALID,
    input  logic [7:0]  DATA_BYTE,
    output logic        DATA_READY,
    output logic        TX_VALID,
    output logic [7:0]  TX_DATA,
    input  logic        TX_READY,
    output logic        LASER_EN,
    output logic        MEAS_EN,
    output logic        CORE_REBOOT
);
    localparam int CW = 16;

    if (PROC_CYC < 1 || PROC_CYC > 65535) begin : g_chk_proc
        $error("PROC_CYC out of range");
    end
    if (DROP_W < 1 || DROP_W > 32) begin : g_chk_drop
        $error("DROP_W out of range");
    end

    // ****************************************************************
    // state
    // ****************************************************************
    rsp_state_e        state_r, state_nxt;
    rsp_state_e        ret_r, ret_nxt;
    rsp_txph_e         ph_r, ph_nxt;
    logic [7:0]        cmd_r, cmd_nxt;
    logic [7:0]        pcmd_r, pcmd_nxt;
    logic              pend_r, pend_nxt;
    logic              fault_r, fault_nxt;
    logic              force_r, force_nxt;
    logic [1:0]        mode_r, mode_nxt;
    rsp_len_t          len_r, len_nxt;
    logic [7:0]        type_r, type_nxt;
    logic [29:0]       idx_r, idx_nxt;
    logic [CW-1:0]     cnt_r, cnt_nxt;
    logic [DROP_W-1:0] drops_r, drops_nxt;
    logic              reboot_r, reboot_nxt;
    logic [7:0]        tx_byte_r;
    logic              tx_vld_r;
    logic              laser_r;
    rsp_len_t          len_q [`RSP_NUM_LEN];
    logic [31:0]       prdata_r;
    logic              pslverr_r;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic motor_ok;
    logic fault_in;

    rsp_sync2 #(
        .W (2)
    ) u_sync (
        .clk (REF_CLK),
        .rst (RST),
        .ce  (CE),
        .d   ({MOTOR_STABLE, HW_FAULT}),
        .q   ({motor_ok, fault_in})
    );

    // ****************************************************************
    // descriptor byte selection
    // ****************************************************************
    logic [7:0] desc_byte;

    rsp_desc_byte u_desc (
        .idx    (idx_r[2:0]),
        .len    (len_r),
        .mode   (mode_r),
        .dtype  (type_r),
        .byte_o (desc_byte)
    );

    // ****************************************************************
    // decode
    // ****************************************************************
    wire logic       is_scan   = (cmd_r == `RSP_CMD_SCAN) || (cmd_r == `RSP_CMD_FAST)
                                 || (cmd_r == `RSP_CMD_FORCE);
    wire logic       is_query  = (cmd_r == `RSP_CMD_IDENT) || (cmd_r == `RSP_CMD_COND)
                                 || (cmd_r == `RSP_CMD_PERIOD) || (cmd_r == `RSP_CMD_CONF);
    wire logic [2:0] cmd_lsel  = rsp_len_idx(cmd_r);
    wire logic       fault_hit = fault_in && !fault_r;
    wire logic       tx_free   = !tx_vld_r || TX_READY;
    wire logic       gate_ok   = (idx_r != 30'h0) || (mode_r == `RSP_MODE_SINGLE)
                                 || force_r || motor_ok;
    wire logic       stop_now  = (ph_r == PH_DATA) && (idx_r == 30'h0) && pend_r
                                 && (mode_r == `RSP_MODE_STREAM);
    wire logic       adv       = tx_free && !stop_now && !fault_hit;
    wire logic       data_go   = adv && (ph_r == PH_DATA) && gate_ok;
    wire logic       emit      = (adv && (ph_r == PH_DESC)) || (data_go && DATA_VALID);
    wire logic       desc_last = (ph_r == PH_DESC) && (idx_r == `RSP_DESC_LAST);
    wire logic       pkt_last  = (ph_r == PH_DATA) && (idx_r == len_r - 30'h1);
    wire logic       proc_fin  = (state_r == ST_PROC) && (ph_r == PH_OFF)
                                 && (cnt_r == CW'(PROC_CYC - 1));
    wire logic       rest_st   = fault_r ? 1'h1 : 1'h0;

    // ****************************************************************
    // control next state
    // ****************************************************************
    always_comb begin
        state_nxt  = state_r;
        ret_nxt    = ret_r;
        ph_nxt     = ph_r;
        cmd_nxt    = cmd_r;
        pcmd_nxt   = pcmd_r;
        pend_nxt   = pend_r;
        fault_nxt  = fault_r;
        force_nxt  = force_r;
        mode_nxt   = mode_r;
        len_nxt    = len_r;
        type_nxt   = type_r;
        idx_nxt    = idx_r;
        cnt_nxt    = cnt_r;
        drops_nxt  = drops_r;
        reboot_nxt = 1'h0;
        if (state_r == ST_PROC && ph_r == PH_OFF && !proc_fin) begin
            cnt_nxt = cnt_r + CW'(1);                                  // [R11]
        end
        if (REQ_VALID) begin
            if (state_r == ST_IDLE || state_r == ST_FAULT) begin
                state_nxt = ST_PROC;                                   // [R11]
                cmd_nxt   = REQ_CMD;
                ret_nxt   = state_r;
                cnt_nxt   = '0;
            end else if (state_r == ST_SCAN && !pend_r) begin
                pend_nxt = 1'h1;                                       // [R24]
                pcmd_nxt = REQ_CMD;
            end else if (drops_r != '1) begin
                drops_nxt = drops_r + DROP_W'(1);                      // [R23]
            end
        end
        if (stop_now) begin
            state_nxt = ST_PROC;                                       // [R24]
            cmd_nxt   = pcmd_r;
            pend_nxt  = 1'h0;
            ret_nxt   = ST_SCAN;
            ph_nxt    = PH_OFF;
            cnt_nxt   = '0;
        end
        if (emit) begin
            idx_nxt = (desc_last || pkt_last) ? 30'h0 : idx_r + 30'h1;
            if (desc_last) begin
                ph_nxt = PH_DATA;                                      // [R1] [R2]
            end else if (pkt_last && mode_r == `RSP_MODE_SINGLE) begin
                ph_nxt    = PH_OFF;                                    // [R20] [R21]
                state_nxt = rest_st ? ST_FAULT : ST_IDLE;              // [R12]
            end
        end
        if (proc_fin) begin
            type_nxt = cmd_r;                                          // [R7]
            len_nxt  = len_q[cmd_lsel];                                // [R4] [R5]
            idx_nxt  = 30'h0;
            case (1'h1)
                (cmd_r == `RSP_CMD_STOP): begin
                    state_nxt = (ret_r == ST_FAULT) ? ST_FAULT : ST_IDLE; // [R16] [R12]
                end
                (cmd_r == `RSP_CMD_REBOOT): begin
                    state_nxt  = ST_IDLE;                              // [R16] [R14]
                    fault_nxt  = 1'h0;
                    reboot_nxt = 1'h1;
                end
                is_scan: begin
                    if (fault_r) begin
                        state_nxt = ST_FAULT;                          // [R14]
                    end else begin
                        state_nxt = ST_SCAN;                           // [R17] [R18] [R10]
                        ph_nxt    = PH_DESC;                           // [R1]
                        mode_nxt  = `RSP_MODE_STREAM;                  // [R6]
                        force_nxt = (cmd_r == `RSP_CMD_FORCE);         // [R19]
                    end
                end
                is_query: begin
                    ph_nxt    = PH_DESC;                               // [R20] [R21]
                    mode_nxt  = `RSP_MODE_SINGLE;                      // [R6]
                    force_nxt = 1'h0;
                end
                default: begin
                    state_nxt = rest_st ? ST_FAULT : ST_IDLE;          // [R12]
                end
            endcase
        end
        if (fault_hit) begin
            state_nxt = ST_FAULT;                                      // [R13]
            ph_nxt    = PH_OFF;
            fault_nxt = 1'h1;
            pend_nxt  = 1'h0;
        end
    end

    // ****************************************************************
    // control registers
    // ****************************************************************
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state_r <= ST_IDLE;                                        // [R9] [R8]
            ret_r   <= ST_IDLE;
            ph_r    <= PH_OFF;
            cmd_r   <= 8'h00;
            pcmd_r  <= 8'h00;
            pend_r  <= 1'h0;
            fault_r <= 1'h0;
            force_r <= 1'h0;
            mode_r  <= `RSP_MODE_SINGLE;
        end else if (CE) begin
            state_r <= state_nxt;
            ret_r   <= ret_nxt;
            ph_r    <= ph_nxt;
            cmd_r   <= cmd_nxt;
            pcmd_r  <= pcmd_nxt;
            pend_r  <= pend_nxt;
            fault_r <= fault_nxt;
            force_r <= force_nxt;
            mode_r  <= mode_nxt;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            len_r    <= `RSP_LEN_RST;
            type_r   <= 8'h00;
            idx_r    <= 30'h0;
            cnt_r    <= '0;
            drops_r  <= '0;
            reboot_r <= 1'h0;
            laser_r  <= 1'h0;
        end else if (CE) begin
            len_r    <= len_nxt;
            type_r   <= type_nxt;
            idx_r    <= idx_nxt;
            cnt_r    <= cnt_nxt;
            drops_r  <= drops_nxt;
            reboot_r <= reboot_nxt;
            laser_r  <= (state_nxt == ST_SCAN);                        // [R9] [R10]
        end
    end

    // ****************************************************************
    // byte output
    // ****************************************************************
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            tx_vld_r  <= 1'h0;
            tx_byte_r <= 8'h00;
        end else if (CE) begin
            if (fault_hit) begin
                tx_vld_r <= 1'h0;                                      // [R13]
            end else if (emit) begin
                tx_vld_r  <= 1'h1;
                tx_byte_r <= (ph_r == PH_DESC) ? desc_byte : DATA_BYTE;
            end else if (TX_READY) begin
                tx_vld_r <= 1'h0;
            end
        end
    end

    assign DATA_READY  = CE && data_go;                                // [R15]
    assign TX_VALID    = tx_vld_r;
    assign TX_DATA     = tx_byte_r;
    assign LASER_EN    = laser_r;
    assign MEAS_EN     = laser_r;
    assign CORE_REBOOT = reboot_r;

    // ****************************************************************
    // apb slave
    // ****************************************************************
    wire logic       apb_setup = PSEL && !PENABLE;
    wire logic       apb_wr    = PSEL && PENABLE && PWRITE;
    wire logic [7:0] len_ofs   = PADDR - `RSP_OFF_LEN0;
    wire logic       in_len    = (PADDR >= `RSP_OFF_LEN0) && (PADDR[1:0] == 2'h0)
                                 && (len_ofs[7:2] < 6'(`RSP_NUM_LEN));
    wire logic [2:0] len_sel   = len_ofs[4:2];
    wire logic       hit_sts   = (PADDR == `RSP_OFF_STATUS);
    wire logic       hit_drp   = (PADDR == `RSP_OFF_DROPS);
    wire logic       addr_ok   = hit_sts || hit_drp || in_len;

    logic [31:0] sts_word;
    always_comb begin
        sts_word                                  = 32'h0;
        sts_word[`RSP_STS_STATE +: 2]             = state_r;
        sts_word[`RSP_STS_PH +: 2]                = ph_r;
        sts_word[`RSP_STS_FAULT]                  = fault_r;
        sts_word[`RSP_STS_PEND]                   = pend_r;
    end

    wire logic [31:0] rd_val = hit_sts ? sts_word
                             : hit_drp ? 32'(drops_r)
                             : in_len  ? {2'h0, len_q[len_sel]}
                             : 32'h0;

    for (genvar i = 0; i < `RSP_NUM_LEN; i++) begin : g_len
        always_ff @(posedge REF_CLK) begin
            if (RST) begin
                len_q[i] <= `RSP_LEN_RST;
            end else if (CE && apb_wr && in_len && len_sel == 3'(i)) begin
                len_q[i] <= PWDATA[29:0];
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            prdata_r  <= 32'h0;
            pslverr_r <= 1'h0;
        end else if (CE && apb_setup) begin
            prdata_r  <= PWRITE ? 32'h0 : rd_val;
            pslverr_r <= !addr_ok || (PWRITE && !in_len);
        end
    end

    assign PRDATA  = prdata_r;
    assign PREADY  = 1'h1;
    assign PSLVERR = pslverr_r && PSEL && PENABLE;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST || !CE);

    sequence s_desc_at(int n);
        emit && ph_r == PH_DESC && idx_r == 30'(n);
    endsequence

    sequence s_stream_open;
        emit && ph_r == PH_DATA && idx_r == 30'h0 && mode_r == `RSP_MODE_STREAM;
    endsequence

    a_sync_first: assert property (s_desc_at(0) |=> TX_VALID && TX_DATA == `RSP_SYNC1) // [R3]
        else $error("descriptor does not open with first sync byte");
    a_sync_second: assert property (s_desc_at(1) |=> TX_DATA == `RSP_SYNC2) // [R3]
        else $error("second sync byte wrong");
    a_len_low_first: assert property (s_desc_at(2) |=> TX_DATA == len_r[7:0]) // [R22]
        else $error("length not sent low byte first");
    a_mode_top_bits: assert property (s_desc_at(5) |=> TX_DATA == {mode_r, len_r[29:24]}) // [R25]
        else $error("send mode not in top bits");
    a_type_byte: assert property (s_desc_at(6) |=> TX_DATA == cmd_r && ph_r == PH_DATA) // [R7]
        else $error("type byte does not follow request");
    a_mode_legal: assert property (ph_r != PH_OFF |-> mode_r[1] == 1'h0) // [R6]
        else $error("reserved send mode in use");
    a_one_desc: assert property (ph_r == PH_DATA |=> ph_r != PH_DESC) // [R2]
        else $error("second descriptor in one session");
    a_len_hold: assert property ((ph_r == PH_DATA) [*2] |-> $stable(len_r)) // [R5]
        else $error("packet length changed inside session");
    a_idle_dark: assert property (state_r == ST_IDLE |-> !LASER_EN && !MEAS_EN) // [R9]
        else $error("emitter on while idle");
    a_scan_lit: assert property (state_r == ST_SCAN |-> LASER_EN && MEAS_EN) // [R10]
        else $error("emitter off while scanning");
    a_proc_wait: assert property (state_r == ST_PROC && ph_r != PH_OFF |-> cnt_r == CW'(PROC_CYC - 1)) // [R11]
        else $error("reply before processing ended");
    a_fault_stop: assert property (fault_hit |=> state_r == ST_FAULT && ph_r == PH_OFF && !TX_VALID) // [R13]
        else $error("fault did not halt");
    a_fault_refuse: assert property (proc_fin && fault_r && is_scan |=> state_r == ST_FAULT) // [R14]
        else $error("scan accepted in fault halt");
    a_motor_gate: assert property ((s_stream_open and !force_r) |-> motor_ok) // [R15]
        else $error("stream before motor stable");
    a_stream_stop: assert property (stop_now && !fault_hit |=> state_r == ST_PROC && cmd_r == $past(pcmd_r)) // [R24]
        else $error("held request not taken after stream");
    a_drop_busy: assert property (REQ_VALID && state_r == ST_PROC && !stop_now && drops_r != '1
                                  |=> drops_r == $past(drops_r) + DROP_W'(1) && cmd_r == $past(cmd_r)) // [R23]
        else $error("request taken while busy");
    a_single_end: assert property (emit && pkt_last && mode_r == `RSP_MODE_SINGLE && !fault_hit
                                   |=> ph_r == PH_OFF && state_r != ST_PROC) // [R20]
        else $error("single reply did not end session");
endmodule

/* dv/rsp_host_model.sv */
`timescale 1ns/1ps
module rsp_host_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready
);
    logic [7:0] rx_q[$];
    int         seed = 43663;
    // ****
    // byte sink, stalls at random
    // ****
    initial tx_ready = 1'b0;
    always @(posedge clk) begin
        if (!rst && tx_valid && tx_ready) begin
            rx_q.push_back(tx_data);
        end
        tx_ready <= ($random(seed) % 4) != 0;
    end
endmodule

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import rsp_pkg::*;
    logic        clk = 0, rst = 1, psel = 0, pen = 0, pw = 0, rv = 0, ms = 0, hf = 0, err;
    logic [7:0]  pa = 0, rc = 0, db = 0, tx_data;
    logic [31:0] pwd = 0, prdata, rd;
    logic        pready, pslverr, dr, tx_valid, tx_ready, laser, meas, rb;
    int          errors = 0, cmp_count = 0, seed = 43663, cyc = 0, rb_n = 0;
    logic [29:0] len;
    logic [7:0]  q[4] = '{8'h50, 8'h52, 8'h59, 8'h84};
    logic [7:0]  s[3] = '{8'h20, 8'h82, 8'h21};
    rsp_top #(.PROC_CYC(2)) i_rsp_top (.REF_CLK(clk), .RST(rst), .CE(1'b1), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pw), .PADDR(pa), .PWDATA(pwd), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .REQ_VALID(rv), .REQ_CMD(rc), .MOTOR_STABLE(ms), .HW_FAULT(hf), .DATA_VALID(1'b1), .DATA_BYTE(db),
        .DATA_READY(dr), .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_READY(tx_ready), .LASER_EN(laser),
        .MEAS_EN(meas), .CORE_REBOOT(rb));
    rsp_host_model i_rsp_host_model (.clk(clk), .rst(rst), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready));
    // ****
    // clock, data source, timeout
    // ****
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        db <= $random(seed);
        cyc++;
        if (rb === 1'b1) rb_n++;
        if (cyc == 20000) begin
            errors++;
            wrap_up();
        end
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pen <= 0;
        pw <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        pen <= 0;
    endtask
    task req(input logic [7:0] c);
        @(posedge clk);
        rv <= 1;
        rc <= c;
        @(posedge clk);
        rv <= 0;
    endtask
    task got(input int k);
        while (i_rsp_host_model.rx_q.size() < k) @(posedge clk);
    endtask
    function automatic logic [7:0] dsc(int i, logic [1:0] m, logic [7:0] t);
        logic [31:0] w;
        w = {m, len};
        return i == 0 ? 8'hA5 : i == 1 ? 8'h5A : i == 6 ? t : w[8*(i-2) +: 8];
    endfunction
    task chk_desc(input logic [1:0] m, input logic [7:0] t);
        for (int i = 0; i < 7; i++) chk(i_rsp_host_model.rx_q[i], dsc(i, m, t));
    endtask
    task setlen(input int i);
        len = ({$random(seed)} % 6) + 1;
        apb(1, 8'h10 + 8'(4 * i), 32'(len));
        apb(0, 8'h10 + 8'(4 * i), 0);
        chk(rd, 32'(len));
        i_rsp_host_model.rx_q.delete();
    endtask
    task wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 0;
        apb(0, 8'h10, 0);
        chk(rd, 32'h5);
        apb(0, 8'h08, 0);
        chk(err, 1);
        for (int k = 0; k < 4; k++) begin
            setlen(3 + k);
            req(q[k]);
            if (k == 0) req(8'h20);
            got(7 + len);
            repeat (20) @(posedge clk);
            chk(i_rsp_host_model.rx_q.size(), 7 + len);
            chk_desc(2'h0, q[k]);
            apb(0, 8'h00, 0);
            chk(rd[1:0], 0);
        end
        apb(0, 8'h04, 0);
        chk(rd, 1);
        $display("queries done");
        for (int k = 0; k < 3; k++) begin
            ms <= 0;
            setlen(k);
            req(s[k]);
            repeat (60) @(posedge clk);
            chk(i_rsp_host_model.rx_q.size() > 7, k == 2);
            chk_desc(2'h1, s[k]);
            chk({laser, meas}, 2'b11);
            if (k < 2) chk(dr, 0);
            ms <= 1;
            got(7 + 2 * len);
            req(8'h25);
            repeat (40) @(posedge clk);
            chk((i_rsp_host_model.rx_q.size() - 7) % len, 0);
            chk({laser, meas}, 2'b00);
        end
        $display("streams done");
        hf <= 1;
        repeat (5) @(posedge clk);
        apb(0, 8'h00, 0);
        chk(rd[1:0], 3);
        setlen(4);
        req(8'h20);
        repeat (30) @(posedge clk);
        chk(i_rsp_host_model.rx_q.size(), 0);
        req(8'h52);
        got(7 + len);
        chk_desc(2'h0, 8'h52);
        hf <= 0;
        repeat (5) @(posedge clk);
        req(8'h40);
        repeat (10) @(posedge clk);
        apb(0, 8'h00, 0);
        chk(rd[1:0], 0);
        chk(rb_n, 1);
        $display("fault done");
        wrap_up();
    end
endmodule
